// ### hdl/apfs_params.svh
// Purpose: Offsets, reset values and pin codes of the address port function select block
// Assumes: Plain strobe register port, 8-bit byte address, 16-bit data
// Notes:   Included by the block itself and by its bench
`ifndef APFS_PARAMS_SVH
`define APFS_PARAMS_SVH

// Register byte offsets
`define APFS_OFS_FUNC    8'h00
`define APFS_OFS_DIR     8'h04
`define APFS_OFS_DATA    8'h08
`define APFS_OFS_PINS    8'h0C

// Reset values and the all-ones word
`define APFS_FUNC_RST    16'h0000
`define APFS_DIR_RST     16'h0000
`define APFS_DATA_RST    16'h0000
`define APFS_ALL_ONES    16'hFFFF

// Operating mode pin codes
`define APFS_MODE_ROM_OFF 2'h0
`define APFS_MODE_ROM_ON  2'h1
`define APFS_MODE_SINGLE  2'h2

`endif

// ### hdl/apfs_pkg.sv
// Purpose: Types of the address port function select block
// Assumes: apfs_params.svh holds every number
// Notes:   Mode enum is decoded from the synchronised mode pins
package apfs_pkg;
   typedef enum logic [1:0] {
      APFS_EXP_ROM_OFF,
      APFS_EXP_ROM_ON,
      APFS_SINGLE_CHIP
   } apfs_mode_t;
endpackage

// ### hdl/apfs_pin_select.sv
// Purpose: Per-pin choice between external address output and general I/O on a 16-pin port
// Assumes: One 20 MHz clock, async active-high reset, mode pins and port pins arrive asynchronously
// Notes:   Pin outputs and enables are registered, so a pin follows its cause one cycle later
`timescale 1ns/1ps
`include "apfs_params.svh"

// Overview of operation
// - In expanded mode with ROM disabled every pin drives its address line whatever its mode bit holds.
// - In expanded mode with ROM enabled a pin whose mode bit is 1 drives its address line.
// - In expanded mode with ROM enabled a pin whose mode bit is 0 is general I/O, and mode bits reset to 0.
// - In single-chip mode every pin is general I/O whatever its mode bit holds.
// - Bit n of the function control register governs port pin n and address line n.
// - With ROM disabled the pins show address output with the mode bits at 0 once the mode filter leaves single chip after reset.
// - Function control clears on reset and in hardware standby and otherwise keeps its value until a write lands.
// - A general I/O pin is an output when its direction bit is 1 and an input when it is 0.
module apfs_pin_select (
   // Clock and reset
   input  wire logic               SYS_CLK,
   input  wire logic               SYS_RST,
   // Power state
   input  wire logic               HW_STANDBY,
   // Operating mode pins
   input  wire logic [1:0]         MODE_PIN,
   output apfs_pkg::apfs_mode_t    MODE_NOW,
   // Register port
   input  wire logic [7:0]         REG_ADDR,
   input  wire logic [15:0]        REG_WDATA,
   input  wire logic               REG_WR,
   input  wire logic               REG_RD,
   output logic      [15:0]        REG_RDATA,
   // Address path from the external bus logic
   input  wire logic [15:0]        ADDR_IN,
   output logic      [15:0]        ADDR_SEL,
   // Port pins
   input  wire logic [15:0]        PIN_IN,
   output logic      [15:0]        PIN_OUT,
   output logic      [15:0]        PIN_OE
);
   import apfs_pkg::*;

   logic [1:0]  mode_s1_q, mode_s2_q, mode_s3_q;
   logic [15:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_lvl_d;
   apfs_mode_t  mode_q, mode_d;
   logic [15:0] func_q, func_d, dir_q, dir_d, data_q, data_d;
   logic [15:0] out_q, out_d, oe_q, oe_d, sel_q, sel_d;
   logic [15:0] rdata_q, rdata_d;

   // Mode and pin filters: a change counts once stages two and three agree
   always_comb begin
      mode_d    = mode_q;
      pin_lvl_d = pin_lvl_q;
      if (mode_s2_q == mode_s3_q) begin
         if (mode_s3_q == `APFS_MODE_ROM_OFF) begin
            mode_d = APFS_EXP_ROM_OFF;
         end else if (mode_s3_q == `APFS_MODE_ROM_ON) begin
            mode_d = APFS_EXP_ROM_ON;
         end else begin
            mode_d = APFS_SINGLE_CHIP;
         end
      end
      for (int i = 0; i < 16; i++) begin
         if (pin_s2_q[i] == pin_s3_q[i]) begin
            pin_lvl_d[i] = pin_s3_q[i];
         end
      end
   end

   // Three-stage synchronisers for the asynchronous inputs
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode_s1_q <= `APFS_MODE_SINGLE;
         mode_s2_q <= `APFS_MODE_SINGLE;
         mode_s3_q <= `APFS_MODE_SINGLE;
         mode_q    <= APFS_SINGLE_CHIP;
         pin_s1_q  <= `APFS_DATA_RST;
         pin_s2_q  <= `APFS_DATA_RST;
         pin_s3_q  <= `APFS_DATA_RST;
         pin_lvl_q <= `APFS_DATA_RST;
      end else begin
         mode_s1_q <= MODE_PIN;
         mode_s2_q <= mode_s1_q;
         mode_s3_q <= mode_s2_q;
         mode_q    <= mode_d;
         pin_s1_q  <= PIN_IN;
         pin_s2_q  <= pin_s1_q;
         pin_s3_q  <= pin_s2_q;
         pin_lvl_q <= pin_lvl_d;
      end
   end

   // Register writes; hardware standby clears control and direction
   always_comb begin
      func_d = func_q;
      dir_d  = dir_q;
      data_d = data_q;
      if (HW_STANDBY) begin
         func_d = `APFS_FUNC_RST;
         dir_d  = `APFS_DIR_RST;
      end else if (REG_WR) begin
         if (REG_ADDR == `APFS_OFS_FUNC) begin
            func_d = REG_WDATA;
         end else if (REG_ADDR == `APFS_OFS_DIR) begin
            dir_d = REG_WDATA;
         end else if (REG_ADDR == `APFS_OFS_DATA) begin
            data_d = REG_WDATA;
         end
      end
   end

   // Register read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (REG_RD) begin
         if (REG_ADDR == `APFS_OFS_FUNC) begin
            rdata_d = func_q;
         end else if (REG_ADDR == `APFS_OFS_DIR) begin
            rdata_d = dir_q;
         end else if (REG_ADDR == `APFS_OFS_DATA) begin
            rdata_d = data_q;
         end else if (REG_ADDR == `APFS_OFS_PINS) begin
            rdata_d = pin_lvl_q;
         end
      end
   end

   // Control registers and read data
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         func_q  <= `APFS_FUNC_RST;
         dir_q   <= `APFS_DIR_RST;
         data_q  <= `APFS_DATA_RST;
         rdata_q <= 16'h0000;
      end else begin
         func_q  <= func_d;
         dir_q   <= dir_d;
         data_q  <= data_d;
         rdata_q <= rdata_d;
      end
   end

   // Per-pin function select
   generate
      for (genvar n = 0; n < 16; n++) begin : g_pin
         always_comb begin
            sel_d[n] = 1'b0;
            case (mode_q)
               APFS_EXP_ROM_OFF: sel_d[n] = 1'b1;
               APFS_EXP_ROM_ON:  sel_d[n] = func_q[n];
               default:          sel_d[n] = 1'b0;
            endcase
            out_d[n] = sel_d[n] ? ADDR_IN[n] : data_q[n];
            oe_d[n]  = sel_d[n] ? 1'b1 : dir_q[n];
         end
      end
   endgenerate

   // Registered pin drive
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         out_q <= `APFS_DATA_RST;
         oe_q  <= `APFS_DIR_RST;
         sel_q <= `APFS_FUNC_RST;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
         sel_q <= sel_d;
      end
   end

   assign PIN_OUT   = out_q;
   assign PIN_OE    = oe_q;
   assign ADDR_SEL  = sel_q;
   assign REG_RDATA = rdata_q;
   assign MODE_NOW  = mode_q;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   // Pin behaviour per mode
   AST_ROM_OFF_ADDR: assert property (
      (mode_q == APFS_EXP_ROM_OFF) |=> (PIN_OE == `APFS_ALL_ONES) && (PIN_OUT == $past(ADDR_IN)))
      else $error("Address not driven with ROM disabled");
   AST_ROM_ON_SET: assert property (
      (mode_q == APFS_EXP_ROM_ON) |=> ((PIN_OE & $past(func_q)) == $past(func_q))
         && ((PIN_OUT & $past(func_q)) == ($past(ADDR_IN) & $past(func_q))))
      else $error("Selected pin not driving address");
   AST_ROM_ON_CLR: assert property (
      (mode_q == APFS_EXP_ROM_ON) |=> ((PIN_OUT & ~$past(func_q)) == ($past(data_q) & ~$past(func_q))))
      else $error("Unselected pin not acting as general I/O");
   AST_SINGLE_IO: assert property (
      (mode_q == APFS_SINGLE_CHIP) |=> (ADDR_SEL == 16'h0000) && (PIN_OUT == $past(data_q)))
      else $error("Pin left as address in single-chip mode");
   AST_BIT_MAP: assert property (
      REG_WR && (REG_ADDR == `APFS_OFS_FUNC) && !HW_STANDBY && (mode_q == APFS_EXP_ROM_ON)
         ##1 (mode_q == APFS_EXP_ROM_ON) |=> (ADDR_SEL == $past(REG_WDATA, 2)))
      else $error("Mode bit does not govern its own pin");
   AST_DEFAULT_ADDR: assert property (
      (func_q == `APFS_FUNC_RST) && (mode_q == APFS_EXP_ROM_OFF) |=> (ADDR_SEL == `APFS_ALL_ONES))
      else $error("Reset state is not address output");
   AST_STANDBY_CLR: assert property (
      HW_STANDBY |=> (func_q == `APFS_FUNC_RST) && (dir_q == `APFS_DIR_RST))
      else $error("Standby did not clear control");
   AST_DIR_OE: assert property (
      (mode_q != APFS_EXP_ROM_OFF) |=> ((PIN_OE & ~ADDR_SEL) == ($past(dir_q) & ~ADDR_SEL)))
      else $error("General I/O enable does not follow direction");
   AST_READ_FUNC: assert property (
      REG_RD && (REG_ADDR == `APFS_OFS_FUNC) |=> (REG_RDATA == $past(func_q))
         ##1 ($past(REG_RD) || (REG_RDATA == 16'h0000)))
      else $error("Control read back wrong");

   // Reset leaves control cleared, pins released and the mode at single chip
   AST_RESET_CLR: assert property (
      disable iff (1'b0) SYS_RST |=> (func_q == `APFS_FUNC_RST) && (dir_q == `APFS_DIR_RST)
         && (PIN_OE == 16'h0000) && (ADDR_SEL == 16'h0000) && (MODE_NOW == APFS_SINGLE_CHIP))
      else $error("Reset did not clear control and pins");

   // An unsettled mode code never moves the filtered mode
   AST_MODE_HOLD: assert property (
      (mode_s2_q != mode_s3_q) |=> $stable(mode_q))
      else $error("Mode changed on an unsettled code");

   // Settled ROM-disabled code selects expanded mode without ROM
   AST_MODE_ROM_OFF: assert property (
      (mode_s2_q == mode_s3_q) && (mode_s3_q == `APFS_MODE_ROM_OFF) |=> (MODE_NOW == APFS_EXP_ROM_OFF))
      else $error("ROM-disabled code not decoded");

   // Settled ROM-enabled code selects expanded mode with ROM
   AST_MODE_ROM_ON: assert property (
      (mode_s2_q == mode_s3_q) && (mode_s3_q == `APFS_MODE_ROM_ON) |=> (MODE_NOW == APFS_EXP_ROM_ON))
      else $error("ROM-enabled code not decoded");

   // Both remaining codes select single chip
   AST_MODE_SINGLE: assert property (
      (mode_s2_q == mode_s3_q) && (mode_s3_q != `APFS_MODE_ROM_OFF) && (mode_s3_q != `APFS_MODE_ROM_ON)
         |=> (MODE_NOW == APFS_SINGLE_CHIP))
      else $error("Single-chip code not decoded");

   // With ROM disabled a set mode bit changes nothing
   AST_ROM_OFF_IGNORE: assert property (
      (mode_q == APFS_EXP_ROM_OFF) && (func_q != `APFS_FUNC_RST) |=> (ADDR_SEL == `APFS_ALL_ONES))
      else $error("Mode bits obeyed with ROM disabled");

   // With ROM enabled each pin follows its own mode bit
   AST_ROM_ON_MAP: assert property (
      (mode_q == APFS_EXP_ROM_ON) |=> (ADDR_SEL == $past(func_q)))
      else $error("Address choice is not the mode bit of its pin");

   // In single chip the enables come from direction alone
   AST_SINGLE_DIR: assert property (
      (mode_q == APFS_SINGLE_CHIP) |=> (PIN_OE == $past(dir_q)))
      else $error("Single-chip pin enable not from direction");

   // An address pin is always driven
   AST_ADDR_OE: assert property (
      (PIN_OE & ADDR_SEL) == ADDR_SEL)
      else $error("Address pin not enabled");

   // An address pin shows its address line one edge late
   AST_ADDR_OUT: assert property (
      1'b1 |=> ((PIN_OUT & ADDR_SEL) == ($past(ADDR_IN) & ADDR_SEL)))
      else $error("Address pin not showing its address line");

   // A general I/O pin shows its output data bit
   AST_IO_OUT: assert property (
      1'b1 |=> ((PIN_OUT & ~ADDR_SEL) == ($past(data_q) & ~ADDR_SEL)))
      else $error("General I/O pin not showing its data bit");

   // Control write lands at the next edge unless standby wins
   AST_WRITE_FUNC: assert property (
      REG_WR && (REG_ADDR == `APFS_OFS_FUNC) && !HW_STANDBY |=> (func_q == $past(REG_WDATA)))
      else $error("Control write lost");

   // Direction write lands at the next edge unless standby wins
   AST_WRITE_DIR: assert property (
      REG_WR && (REG_ADDR == `APFS_OFS_DIR) && !HW_STANDBY |=> (dir_q == $past(REG_WDATA)))
      else $error("Direction write lost");

   // Output data write lands at the next edge outside standby
   AST_WRITE_DATA: assert property (
      REG_WR && (REG_ADDR == `APFS_OFS_DATA) && !HW_STANDBY |=> (data_q == $past(REG_WDATA)))
      else $error("Output data write lost");

   // Control keeps its value while nothing writes or clears it
   AST_FUNC_KEEP: assert property (
      !(REG_WR && (REG_ADDR == `APFS_OFS_FUNC)) && !HW_STANDBY |=> $stable(func_q))
      else $error("Control changed with no write");

   // Direction reads back in the cycle after the strobe
   AST_READ_DIR: assert property (
      REG_RD && (REG_ADDR == `APFS_OFS_DIR) |=> (REG_RDATA == $past(dir_q)))
      else $error("Direction read back wrong");

   // Filtered pin levels read back in the cycle after the strobe
   AST_READ_PINS: assert property (
      REG_RD && (REG_ADDR == `APFS_OFS_PINS) |=> (REG_RDATA == $past(pin_lvl_q)))
      else $error("Pin level read back wrong");

   // No strobe, no read data
   AST_READ_IDLE: assert property (
      !REG_RD |=> (REG_RDATA == 16'h0000))
      else $error("Read data standing without a strobe");

   // Reads outside the map return zero
   AST_READ_UNMAPPED: assert property (
      REG_RD && (REG_ADDR != `APFS_OFS_FUNC) && (REG_ADDR != `APFS_OFS_DIR)
         && (REG_ADDR != `APFS_OFS_DATA) && (REG_ADDR != `APFS_OFS_PINS) |=> (REG_RDATA == 16'h0000))
      else $error("Unmapped read not zero");

   // A pin level is taken once stages two and three agree
   AST_PIN_TAKE: assert property (
      (pin_s2_q == pin_s3_q) |=> (pin_lvl_q == $past(pin_s3_q)))
      else $error("Settled pin level not taken");
endmodule

// ### verification/apfs_bus_model.sv
// Purpose: Far side of the port: external bus address source and the pin wires
// Assumes: Address held steady until the bench asks for the next one
// Notes:   Undriven pins show a pattern that flips every cycle, never the last driven value
`timescale 1ns/1ps
module apfs_bus_model (
   // Clock and step request
   input  wire logic        clk,
   input  wire logic        next,
   // Pin drive from the block
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   // Address and resolved pin levels
   output logic      [15:0] addr,
   output logic      [15:0] pin_wire
);
   logic [15:0] idle_q = 16'hA5C3;
   initial addr = 16'h1234;
   // Released pins toggle; a new address only on request
   always @(posedge clk) begin
      idle_q <= ~idle_q;
      if (next) begin
         addr <= addr * 16'h0005 + 16'h3B79;
      end
   end
   // Wire level from the block's enables
   assign pin_wire = (pin_out & pin_oe) | (idle_q & ~pin_oe);
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench of the address port function select block
// Assumes: Register offsets and mode codes from apfs_params.svh
// Notes:   Random register contents from a fixed-seed xorshift
`timescale 1ns/1ps
`include "apfs_params.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module testbench;
   import apfs_pkg::*;
   logic clk = 0, rst = 1, stby = 0, wr = 0, rd = 0, next = 0;
   logic [1:0]  mode_pin = `APFS_MODE_ROM_OFF;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, addr_in, addr_sel, pin_in, pin_out, pin_oe;
   apfs_mode_t  mode_now;
   int          failures = 0, cmp_count = 0;
   logic [31:0] seed = 32881;
   logic [15:0] f, d, w, sel;
   // Clock of 50 ns
   always #25 clk = ~clk;
   apfs_pin_select u_apfs_pin_select (.SYS_CLK(clk), .SYS_RST(rst), .HW_STANDBY(stby), .MODE_PIN(mode_pin),
      .MODE_NOW(mode_now), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .ADDR_IN(addr_in), .ADDR_SEL(addr_sel), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
   apfs_bus_model u_apfs_bus_model (.clk(clk), .next(next), .pin_out(pin_out), .pin_oe(pin_oe),
      .addr(addr_in), .pin_wire(pin_in));
   // Xorshift source
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   // Pins expected on the address path for mode code m and control word fc
   function automatic logic [15:0] exp_sel(input int m, input logic [15:0] fc);
      if (m == 0) return `APFS_ALL_ONES;
      if (m == 1) return fc;
      return 16'h0000;
   endfunction
   // One write cycle
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk) begin addr <= a; wdata <= v; wr <= 1; end
      @(posedge clk) wr <= 0;
   endtask
   // One read cycle, data taken in the following cycle
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk) begin addr <= a; rd <= 1; end
      @(posedge clk) rd <= 0;
      @(negedge clk) `CHK("read data", e, rdata)
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      failures++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      // Reset values and default address drive
      rd_chk(`APFS_OFS_FUNC, `APFS_FUNC_RST);
      rd_chk(`APFS_OFS_DIR, `APFS_DIR_RST);
      repeat (8) @(negedge clk);
      `CHK("sel after reset", `APFS_ALL_ONES, addr_sel)
      $display("Reset test done");
      // Every mode code with random control, direction and data
      for (int m = 0; m < 4; m++) begin
         @(posedge clk) mode_pin <= m[1:0];
         repeat (8) @(posedge clk);
         @(negedge clk) `CHK("mode", (m > 1) ? APFS_SINGLE_CHIP : apfs_mode_t'(m), mode_now)
         for (int k = 0; k < 5; k++) begin
            f = (k == 0) ? 16'h2000 : (k == 1) ? 16'h0000 : rnd();
            d = rnd();
            w = rnd();
            wr_reg(`APFS_OFS_FUNC, f);
            wr_reg(`APFS_OFS_DIR, d);
            wr_reg(`APFS_OFS_DATA, w);
            @(posedge clk) next <= 1;
            @(posedge clk) next <= 0;
            repeat (3) @(negedge clk);
            sel = exp_sel(m, f);
            `CHK("addr_sel", sel, addr_sel)
            `CHK("pin_oe", sel | d, pin_oe)
            `CHK("pin_out", (sel & addr_in) | (~sel & w), pin_out)
            rd_chk(`APFS_OFS_FUNC, f);
         end
         $display("Mode %0d test done", m);
      end
      // Every pin driven as general I/O reads back through the input filter
      w = rnd();
      wr_reg(`APFS_OFS_DIR, `APFS_ALL_ONES);
      wr_reg(`APFS_OFS_DATA, w);
      wr_reg(`APFS_OFS_FUNC, 16'h5A5A);
      repeat (8) @(posedge clk);
      rd_chk(`APFS_OFS_PINS, w);
      rd_chk(`APFS_OFS_DATA, w);
      $display("Pin level test done");
      // Unmapped read, then standby clears the nonzero control and direction
      rd_chk(8'h10, 16'h0000);
      @(posedge clk) stby <= 1;
      @(posedge clk) stby <= 0;
      rd_chk(`APFS_OFS_FUNC, `APFS_FUNC_RST);
      rd_chk(`APFS_OFS_DIR, `APFS_DIR_RST);
      repeat (2) @(negedge clk);
      `CHK("pin_oe after standby", 16'h0000, pin_oe)
      $display("Standby test done");
      // Reset in mid-run clears a nonzero control word
      wr_reg(`APFS_OFS_FUNC, 16'hA5A5);
      @(posedge clk) rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      rd_chk(`APFS_OFS_FUNC, `APFS_FUNC_RST);
      $display("Mid-run reset test done");
      summarize();
   end
endmodule
